// ===== pkg/oad_pkg.sv
package oad_pkg;
  localparam int OAD_DW = 16;

  typedef enum logic [2:0] {
    OAD_M_DIRECT, OAD_M_IND, OAD_M_POSTDEC, OAD_M_POSTINC,
    OAD_M_PREDEC, OAD_M_PREINC, OAD_M_OFFSET, OAD_M_UNUSED
  } oad_mode_t;

  localparam logic [3:0] OAD_PF_NONE     = 4'h4;
  localparam logic [3:0] OAD_PF_OFFSET   = 4'hC;
  localparam logic [7:0] OAD_OPC_ADDF    = 8'hB4;
  localparam int         OAD_FADDR_W     = 13;
  localparam logic [15:0] OAD_WB_STEP    = 16'h0002;
  localparam logic [15:0] OAD_RST_VAL    = 16'h0000;

  typedef struct packed {
    logic        valid;
    logic        use_second;
    logic [15:0] addr;
    logic [15:0] new_ptr;
    logic        ptr_wr;
    logic [1:0]  dest;
  } oad_pf_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  op_a;
    logic [1:0]  op_b;
  } oad_mul_t;

  typedef struct packed {
    logic        reg_wr;
    logic        mem_wr;
    logic [15:0] addr;
    logic [15:0] new_target;
    logic        invalid;
  } oad_wb_t;
endpackage

// ===== core/oad_mode_dec.sv
`timescale 1ns/1ps
module oad_mode_dec
  import oad_pkg::*;
(
  input  wire logic [2:0] code_i,
  input  wire logic       offset_form_i,
  output oad_mode_t       mode_o
);
  always_comb begin
    case (code_i)
      3'h0:    mode_o = OAD_M_DIRECT;
      3'h1:    mode_o = OAD_M_IND;
      3'h2:    mode_o = OAD_M_POSTDEC;
      3'h3:    mode_o = OAD_M_POSTINC;
      3'h4:    mode_o = OAD_M_PREDEC;
      3'h5:    mode_o = OAD_M_PREINC;
      default: mode_o = offset_form_i ? OAD_M_OFFSET : OAD_M_UNUSED;
    endcase
  end
endmodule

// ===== core/oad_prefetch.sv
`timescale 1ns/1ps
module oad_prefetch
  import oad_pkg::*;
(
  input  wire logic [3:0]  op_i,
  input  wire logic [1:0]  dest_i,
  input  wire logic [15:0] ptr_first_i,
  input  wire logic [15:0] ptr_second_i,
  input  wire logic [15:0] offset_i,
  output oad_pf_t          pf_o
);
  logic [15:0] ptr;
  logic [15:0] step;

  always_comb begin
    ptr  = op_i[3] ? ptr_second_i : ptr_first_i;
    case (op_i[2:0])
      3'h1:    step = 16'h0002;
      3'h2:    step = 16'h0004;
      3'h3:    step = 16'h0006;
      3'h5:    step = 16'hFFFA;
      3'h6:    step = 16'hFFFC;
      3'h7:    step = 16'hFFFE;
      default: step = 16'h0000;
    endcase
    pf_o.valid      = (op_i != OAD_PF_NONE);
    pf_o.use_second = op_i[3];
    pf_o.dest       = dest_i;
    // Address formed from the old pointer, update follows
    pf_o.addr       = (op_i == OAD_PF_OFFSET) ? ptr + offset_i : ptr;
    pf_o.new_ptr    = ptr + step;
    pf_o.ptr_wr     = pf_o.valid && (op_i != OAD_PF_OFFSET) && (step != 16'h0000);
  end
endmodule

// ===== core/oad_decoder.sv
`timescale 1ns/1ps
module oad_decoder
  import oad_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              instr_valid_i,
  input  wire logic [2:0]        src_mode_i,
  input  wire logic [2:0]        dst_mode_i,
  input  wire logic              offset_form_i,
  input  wire logic [3:0]        x_op_i,
  input  wire logic [1:0]        x_dest_field_i,
  input  wire logic [3:0]        y_op_i,
  input  wire logic [1:0]        y_dest_field_i,
  input  wire logic              mul_same_i,
  input  wire logic [1:0]        square_select_field_i,
  input  wire logic [2:0]        pair_select_i,
  input  wire logic [1:0]        writeback_select_field_i,
  input  wire logic [23:0]       addf_word_i,
  input  wire logic [15:0]       x_pointer_first_i,
  input  wire logic [15:0]       x_pointer_second_i,
  input  wire logic [15:0]       y_pointer_first_i,
  input  wire logic [15:0]       y_pointer_second_i,
  input  wire logic [15:0]       prefetch_offset_reg_i,
  input  wire logic [15:0]       writeback_target_reg_i,
  input  wire logic [15:0]       source_reg_i,
  input  wire logic [15:0]       dest_reg_i,
  input  wire logic [15:0]       base_reg_i,
  input  wire logic [15:0]       default_work_reg_i,
  input  wire logic [15:0]       file_data_i,
  output oad_mode_t              src_mode_o,
  output oad_mode_t              dst_mode_o,
  output logic [15:0]            src_ea_o,
  output logic [15:0]            dst_ea_o,
  output logic                   force_reset_o,
  output logic                   src_invalid_o,
  output oad_pf_t                x_pf_o,
  output oad_pf_t                y_pf_o,
  output oad_mul_t               mul_o,
  output oad_wb_t                wb_o,
  output logic                   addf_valid_o,
  output logic [OAD_FADDR_W-1:0] addf_addr_o,
  output logic                   addf_to_file_o,
  output logic                   addf_byte_o,
  output logic [15:0]            addf_result_o
);
  oad_mode_t   src_m;
  oad_mode_t   dst_m;
  oad_pf_t     x_pf;
  oad_pf_t     y_pf;
  oad_mul_t    nxt_mul;
  oad_wb_t     nxt_wb;
  logic [15:0] nxt_src_ea;
  logic [15:0] nxt_dst_ea;
  logic [15:0] nxt_sum;
  logic        nxt_addf;
  logic        nxt_force_rst;
  logic        nxt_src_inv;
  oad_pf_t     nxt_x_pf;
  oad_pf_t     nxt_y_pf;

  oad_mode_t   src_mode_ff;
  oad_mode_t   dst_mode_ff;
  logic [15:0] src_ea_ff;
  logic [15:0] dst_ea_ff;
  logic        force_reset_ff;
  logic        src_invalid_ff;
  oad_pf_t     x_pf_ff;
  oad_pf_t     y_pf_ff;
  oad_mul_t    mul_ff;
  oad_wb_t     wb_ff;
  logic        addf_valid_ff;
  logic [12:0] addf_addr_ff;
  logic        addf_to_file_ff;
  logic        addf_byte_ff;
  logic [15:0] addf_result_ff;

  oad_mode_dec u_src_dec (
    .code_i       (src_mode_i),
    .offset_form_i(offset_form_i),
    .mode_o       (src_m)
  );

  oad_mode_dec u_dst_dec (
    .code_i       (dst_mode_i),
    .offset_form_i(offset_form_i),
    .mode_o       (dst_m)
  );

  oad_prefetch u_x_pf (
    .op_i        (x_op_i),
    .dest_i      (x_dest_field_i),
    .ptr_first_i (x_pointer_first_i),
    .ptr_second_i(x_pointer_second_i),
    .offset_i    (prefetch_offset_reg_i),
    .pf_o        (x_pf)
  );

  oad_prefetch u_y_pf (
    .op_i        (y_op_i),
    .dest_i      (y_dest_field_i),
    .ptr_first_i (y_pointer_first_i),
    .ptr_second_i(y_pointer_second_i),
    .offset_i    (prefetch_offset_reg_i),
    .pf_o        (y_pf)
  );

  function automatic logic [15:0] ea_of(input oad_mode_t m, input logic [15:0] r,
                                        input logic [15:0] b);
    case (m)
      OAD_M_PREDEC: ea_of = r - OAD_WB_STEP;
      OAD_M_PREINC: ea_of = r + OAD_WB_STEP;
      OAD_M_OFFSET: ea_of = r + b;
      default:      ea_of = r;
    endcase
  endfunction

  always_comb begin
    nxt_src_ea = ea_of(src_m, source_reg_i, base_reg_i);
    nxt_dst_ea = ea_of(dst_m, dest_reg_i, base_reg_i);
    nxt_force_rst = instr_valid_i && (dst_m == OAD_M_UNUSED);
    nxt_src_inv   = instr_valid_i && (src_m == OAD_M_UNUSED);
    // Idle slots carry no fetch, so no pointer moves
    nxt_x_pf      = instr_valid_i ? x_pf : '0;
    nxt_y_pf      = instr_valid_i ? y_pf : '0;
    nxt_mul    = '0;
    if (mul_same_i) begin
      nxt_mul.valid = 1'b1;
      nxt_mul.op_a  = square_select_field_i;
      nxt_mul.op_b  = square_select_field_i;
    end else begin
      nxt_mul.valid = (pair_select_i[1:0] != 2'h3);
      case (pair_select_i)
        3'h0:    begin nxt_mul.op_a = 2'h0; nxt_mul.op_b = 2'h1; end
        3'h1:    begin nxt_mul.op_a = 2'h0; nxt_mul.op_b = 2'h2; end
        3'h2:    begin nxt_mul.op_a = 2'h0; nxt_mul.op_b = 2'h3; end
        3'h4:    begin nxt_mul.op_a = 2'h1; nxt_mul.op_b = 2'h2; end
        3'h5:    begin nxt_mul.op_a = 2'h1; nxt_mul.op_b = 2'h3; end
        3'h6:    begin nxt_mul.op_a = 2'h2; nxt_mul.op_b = 2'h3; end
        default: begin nxt_mul.op_a = 2'h0; nxt_mul.op_b = 2'h0; end
      endcase
    end
    nxt_wb            = '0;
    nxt_wb.addr       = writeback_target_reg_i;
    nxt_wb.new_target = writeback_target_reg_i;
    case (writeback_select_field_i)
      2'h0: nxt_wb.reg_wr = 1'b1;
      2'h1: begin
        nxt_wb.mem_wr     = 1'b1;
        nxt_wb.new_target = writeback_target_reg_i + OAD_WB_STEP;
      end
      2'h3:    nxt_wb.invalid = 1'b1;
      default: nxt_wb.invalid = 1'b0;
    endcase
    if (!instr_valid_i) begin
      nxt_mul = '0;
      nxt_wb  = '0;
    end
    nxt_addf = instr_valid_i && (addf_word_i[23:16] == OAD_OPC_ADDF);
    if (addf_word_i[14]) begin
      nxt_sum = {8'h00, file_data_i[7:0] + default_work_reg_i[7:0]};
    end else begin
      nxt_sum = file_data_i + default_work_reg_i;
    end
  end

  // All decodes of one instruction land together on the next edge
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      src_mode_ff     <= OAD_M_DIRECT;
      dst_mode_ff     <= OAD_M_DIRECT;
      src_ea_ff       <= OAD_RST_VAL;
      dst_ea_ff       <= OAD_RST_VAL;
      force_reset_ff  <= 1'b0;
      src_invalid_ff  <= 1'b0;
      x_pf_ff         <= '0;
      y_pf_ff         <= '0;
      mul_ff          <= '0;
      wb_ff           <= '0;
      addf_valid_ff   <= 1'b0;
      addf_addr_ff    <= '0;
      addf_to_file_ff <= 1'b0;
      addf_byte_ff    <= 1'b0;
      addf_result_ff  <= OAD_RST_VAL;
    end else begin
      src_mode_ff     <= src_m;
      dst_mode_ff     <= dst_m;
      src_ea_ff       <= nxt_src_ea;
      dst_ea_ff       <= nxt_dst_ea;
      force_reset_ff  <= nxt_force_rst;
      src_invalid_ff  <= nxt_src_inv;
      x_pf_ff         <= nxt_x_pf;
      y_pf_ff         <= nxt_y_pf;
      mul_ff          <= nxt_mul;
      wb_ff           <= nxt_wb;
      addf_valid_ff   <= nxt_addf;
      addf_addr_ff    <= addf_word_i[OAD_FADDR_W-1:0];
      addf_to_file_ff <= addf_word_i[13];
      addf_byte_ff    <= addf_word_i[14];
      addf_result_ff  <= nxt_sum;
    end
  end

  assign src_mode_o     = src_mode_ff;
  assign dst_mode_o     = dst_mode_ff;
  assign src_ea_o       = src_ea_ff;
  assign dst_ea_o       = dst_ea_ff;
  assign force_reset_o  = force_reset_ff;
  assign src_invalid_o  = src_invalid_ff;
  assign x_pf_o         = x_pf_ff;
  assign y_pf_o         = y_pf_ff;
  assign mul_o          = mul_ff;
  assign wb_o           = wb_ff;
  assign addf_valid_o   = addf_valid_ff;
  assign addf_addr_o    = addf_addr_ff;
  assign addf_to_file_o = addf_to_file_ff;
  assign addf_byte_o    = addf_byte_ff;
  assign addf_result_o  = addf_result_ff;

  a_dst_reset_force: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && dst_mode_i[2:1] == 2'h3 && !offset_form_i |=> force_reset_o)
    else $error("destination 11x did not force reset");
  a_src_unused_flag: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && src_mode_i[2:1] == 2'h3 && !offset_form_i |=> src_invalid_o)
    else $error("unused source mode not flagged");
  a_src_offset_ea: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    offset_form_i && src_mode_i[2:1] == 2'h3
    |=> src_ea_o == $past(source_reg_i) + $past(base_reg_i))
    else $error("source offset address wrong");
  a_dst_offset_ea: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    offset_form_i && dst_mode_i[2:1] == 2'h3
    |=> dst_ea_o == $past(dest_reg_i) + $past(base_reg_i))
    else $error("destination offset address wrong");
  a_x_none_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    x_op_i == 4'h4 |=> !x_pf_o.valid && !x_pf_o.ptr_wr)
    else $error("X no-fetch code still fetched");
  a_y_none_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    y_op_i == 4'h4 |=> !y_pf_o.valid && !y_pf_o.ptr_wr)
    else $error("Y no-fetch code still fetched");
  a_x_post_dec: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && x_op_i == 4'h5
    |=> x_pf_o.addr == $past(x_pointer_first_i)
        && x_pf_o.new_ptr == $past(x_pointer_first_i) - 16'h0006)
    else $error("X post-decrement by 6 wrong");
  a_y_offset_read: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && y_op_i == 4'hC
    |=> y_pf_o.addr == $past(y_pointer_second_i) + $past(prefetch_offset_reg_i)
        && !y_pf_o.ptr_wr)
    else $error("Y offset read wrong");
  a_pair_invalid: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && !mul_same_i && pair_select_i[1:0] == 2'h3 |=> !mul_o.valid)
    else $error("invalid multiplier pair accepted");
  a_wb_post_inc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && writeback_select_field_i == 2'h1
    |=> wb_o.mem_wr && wb_o.new_target == $past(writeback_target_reg_i) + 16'h0002)
    else $error("write-back post-increment wrong");
  a_src_mode_basic: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    src_mode_i < 3'h6 |=> src_mode_o == $past(src_mode_i))
    else $error("basic source mode decoded wrong");
  a_dst_mode_basic: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    dst_mode_i < 3'h6 |=> dst_mode_o == $past(dst_mode_i))
    else $error("basic destination mode decoded wrong");
  a_x_first_inc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && x_op_i == 4'h3
    |=> x_pf_o.valid && x_pf_o.ptr_wr && x_pf_o.addr == $past(x_pointer_first_i)
        && x_pf_o.new_ptr == $past(x_pointer_first_i) + 16'h0006)
    else $error("X post-increment by 6 wrong");
  a_x_second_dec: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && x_op_i == 4'hF
    |=> x_pf_o.use_second && x_pf_o.addr == $past(x_pointer_second_i)
        && x_pf_o.new_ptr == $past(x_pointer_second_i) - 16'h0002)
    else $error("X second pointer fetch wrong");
  a_x_offset_read: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && x_op_i == 4'hC
    |=> x_pf_o.addr == $past(x_pointer_second_i) + $past(prefetch_offset_reg_i)
        && !x_pf_o.ptr_wr)
    else $error("X offset read wrong");
  a_x_dest_pick: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i |=> x_pf_o.dest == $past(x_dest_field_i))
    else $error("X destination select wrong");
  a_y_first_dec: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && y_op_i == 4'h7
    |=> y_pf_o.valid && !y_pf_o.use_second && y_pf_o.addr == $past(y_pointer_first_i)
        && y_pf_o.new_ptr == $past(y_pointer_first_i) - 16'h0002)
    else $error("Y post-decrement by 2 wrong");
  a_y_second_inc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && y_op_i == 4'h9
    |=> y_pf_o.use_second && y_pf_o.addr == $past(y_pointer_second_i)
        && y_pf_o.new_ptr == $past(y_pointer_second_i) + 16'h0002)
    else $error("Y second pointer fetch wrong");
  a_y_dest_pick: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i |=> y_pf_o.dest == $past(y_dest_field_i))
    else $error("Y destination select wrong");
  a_square_same: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && mul_same_i
    |=> mul_o.valid && mul_o.op_a == $past(square_select_field_i)
        && mul_o.op_b == $past(square_select_field_i))
    else $error("square operand select wrong");
  a_wb_direct: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && writeback_select_field_i == 2'h0
    |=> wb_o.reg_wr && !wb_o.mem_wr && wb_o.addr == $past(writeback_target_reg_i))
    else $error("direct write-back wrong");
  a_wb_none: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && writeback_select_field_i == 2'h2
    |=> !wb_o.reg_wr && !wb_o.mem_wr && !wb_o.invalid)
    else $error("no-write-back select still wrote");
  a_addf_detect: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && addf_word_i[23:16] == OAD_OPC_ADDF |=> addf_valid_o)
    else $error("file-register add not detected");
  a_addf_dest_bit: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i |=> addf_to_file_o == $past(addf_word_i[13]))
    else $error("add destination select wrong");
  a_addf_word_sum: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i && !addf_word_i[14]
    |=> addf_result_o == $past(file_data_i) + $past(default_work_reg_i))
    else $error("word add result wrong");
  a_addf_file_addr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_valid_i |=> addf_addr_o == $past(addf_word_i[12:0]))
    else $error("file address field wrong");
  a_pf_idle_slot: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !instr_valid_i |=> !x_pf_o.valid && !y_pf_o.valid)
    else $error("prefetch issued in idle slot");
endmodule

// ===== verif/oad_fetch_model.sv
`timescale 1ns/1ps
module oad_fetch_model (
  input  wire logic        clk_i,
  output logic             instr_valid_o,
  output logic [23:0]      word_o
);
  logic [23:0] last;

  initial begin
    instr_valid_o = 1'b0;
    word_o        = 24'h000000;
    last          = 24'h000000;
  end

  // Idle slots show the inverse of the last word, never a stale copy
  task automatic present(input logic v, input logic [23:0] w);
    @(negedge clk_i);
    instr_valid_o = v;
    word_o        = v ? w : ~last;
    if (v) begin
      last = w;
    end
  endtask
endmodule

// ===== verif/operand_address_decode_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, (g), (e)); end end
module operand_address_decode_tb_top
  import oad_pkg::*;
;
  logic                   sys_clk, nrst, ivld, off, msame;
  logic [2:0]             sm, dm, ps;
  logic [3:0]             xo, yo;
  logic [1:0]             xd, yd, sq, wbs;
  logic [23:0]            aw;
  logic [15:0]            x1, x2, y1, y2, pofs, wtg, sr, dr, br, wr, fd;
  oad_mode_t              smo, dmo;
  logic [15:0]            sea, dea, ares;
  logic                   frst, sinv, avld, afile, abyte;
  logic [OAD_FADDR_W-1:0] aadr;
  oad_pf_t                xpf, ypf;
  oad_mul_t               mul;
  oad_wb_t                wb;
  int                     n_mismatch, tests_run;

  oad_fetch_model i_fetch (.clk_i(sys_clk), .instr_valid_o(ivld), .word_o(aw));

  oad_decoder i_dut (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .instr_valid_i(ivld), .src_mode_i(sm),
    .dst_mode_i(dm), .offset_form_i(off), .x_op_i(xo), .x_dest_field_i(xd), .y_op_i(yo),
    .y_dest_field_i(yd), .mul_same_i(msame), .square_select_field_i(sq),
    .pair_select_i(ps), .writeback_select_field_i(wbs), .addf_word_i(aw),
    .x_pointer_first_i(x1), .x_pointer_second_i(x2), .y_pointer_first_i(y1),
    .y_pointer_second_i(y2), .prefetch_offset_reg_i(pofs), .writeback_target_reg_i(wtg),
    .source_reg_i(sr), .dest_reg_i(dr), .base_reg_i(br), .default_work_reg_i(wr),
    .file_data_i(fd), .src_mode_o(smo), .dst_mode_o(dmo), .src_ea_o(sea), .dst_ea_o(dea),
    .force_reset_o(frst), .src_invalid_o(sinv), .x_pf_o(xpf), .y_pf_o(ypf), .mul_o(mul),
    .wb_o(wb), .addf_valid_o(avld), .addf_addr_o(aadr), .addf_to_file_o(afile),
    .addf_byte_o(abyte), .addf_result_o(ares)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apply(input logic v, input logic [23:0] w);
    i_fetch.present(v, w);
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  function automatic logic [15:0] ea_exp(input logic [2:0] c, input logic [15:0] r);
    case (c)
      3'h4: ea_exp = r - 16'h0002;
      3'h5: ea_exp = r + 16'h0002;
      3'h6, 3'h7: ea_exp = r + br;
      default: ea_exp = r;
    endcase
  endfunction

  task automatic t_modes;
    oad_mode_t em;
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 8; c++) begin
        off = f[0];
        sm  = c[2:0];
        dm  = c[2:0];
        apply(1'b1, 24'h000000);
        em = (c < 6) ? oad_mode_t'(c[2:0]) : (f[0] ? OAD_M_OFFSET : OAD_M_UNUSED);
        `CHK(smo, em)
        `CHK(dmo, em)
        `CHK(frst, (f == 0 && c > 5))
        `CHK(sinv, (f == 0 && c > 5))
        if (c < 6 || f == 1) begin
          `CHK(sea, ea_exp(c[2:0], sr))
          `CHK(dea, ea_exp(c[2:0], dr))
        end
      end
    end
  endtask

  task automatic chk_pf(input oad_pf_t p, input logic [3:0] op, input logic [15:0] a,
                        input logic [15:0] b, input logic [1:0] d);
    logic [15:0] st;
    logic        nop;
    case (op[2:0])
      3'h1: st = 16'h0002;
      3'h2: st = 16'h0004;
      3'h3: st = 16'h0006;
      3'h5: st = 16'hFFFA;
      3'h6: st = 16'hFFFC;
      3'h7: st = 16'hFFFE;
      default: st = 16'h0000;
    endcase
    nop = (op == OAD_PF_NONE);
    `CHK(p.valid, !nop)
    if (!nop) begin
      `CHK(p.use_second, op[3])
      `CHK(p.dest, d)
      `CHK(p.addr, (op == OAD_PF_OFFSET) ? b + pofs : (op[3] ? b : a))
      `CHK(p.ptr_wr, (op != OAD_PF_OFFSET && st != 16'h0000))
      if (op != OAD_PF_OFFSET) begin
        `CHK(p.new_ptr, (op[3] ? b : a) + st)
      end
    end else begin
      `CHK(p.ptr_wr, 1'b0)
    end
  endtask

  task automatic t_prefetch;
    for (int op = 0; op < 16; op++) begin
      xo = op[3:0];
      yo = op[3:0];
      xd = op[1:0];
      yd = ~op[1:0];
      apply(1'b1, 24'h000000);
      chk_pf(xpf, op[3:0], x1, x2, op[1:0]);
      chk_pf(ypf, op[3:0], y1, y2, ~op[1:0]);
    end
    dm  = 3'h7;
    off = 1'b0;
    apply(1'b0, 24'h000000);
    `CHK(xpf, '0)
    `CHK(frst, 1'b0)
  endtask

  task automatic t_mul;
    logic [1:0] pa [8];
    logic [1:0] pb [8];
    pa = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
    pb = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h3, 2'h0};
    msame = 1'b1;
    for (int c = 0; c < 4; c++) begin
      sq = c[1:0];
      apply(1'b1, 24'h000000);
      `CHK(mul, {1'b1, c[1:0], c[1:0]})
    end
    msame = 1'b0;
    for (int c = 0; c < 8; c++) begin
      ps = c[2:0];
      apply(1'b1, 24'h000000);
      `CHK(mul.valid, (c[1:0] != 2'h3))
      if (c[1:0] != 2'h3) begin
        `CHK({mul.op_a, mul.op_b}, {pa[c], pb[c]})
      end
    end
  endtask

  task automatic t_wb_addf;
    logic [23:0] w;
    for (int c = 0; c < 4; c++) begin
      wbs = c[1:0];
      w   = {OAD_OPC_ADDF, 1'b0, c[1], c[0], 13'h1FFF};
      apply(1'b1, w);
      `CHK({wb.reg_wr, wb.mem_wr, wb.invalid}, {c == 0, c == 1, c == 3})
      if (c == 1) begin
        `CHK({wb.addr, wb.new_target}, {wtg, wtg + OAD_WB_STEP})
      end
      `CHK({avld, aadr}, {1'b1, 13'h1FFF})
      `CHK(afile, c[0])
      `CHK(abyte, c[1])
      `CHK(ares, c[1] ? {8'h00, wr[7:0] + fd[7:0]} : wr + fd)
    end
    apply(1'b1, 24'hB06123);
    `CHK(avld, 1'b0)
  endtask

  initial begin
    {nrst, off, msame, sm, dm, ps, xo, yo, xd, yd, sq, wbs} = '0;
    {x1, x2, y1, y2} = {16'h0002, 16'hFFFC, 16'h1000, 16'h0004};
    {pofs, wtg, sr, dr, br} = {16'h0010, 16'hFFFE, 16'h1234, 16'h0001, 16'h0F0E};
    {wr, fd} = {16'hCC80, 16'hFFC0};
    n_mismatch = 0;
    tests_run  = 0;
    repeat (8) @(negedge sys_clk);
    `CHK({xpf, ypf, mul, wb, frst, sinv, avld, ares}, '0)
    `CHK(smo, OAD_M_DIRECT)
    nrst = 1'b1;
    t_modes();
    t_prefetch();
    t_mul();
    t_wb_addf();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
endmodule
